/* File: rtl/fdc_pkg.sv */
package fdc_pkg;
   // ----------------------------------------------------------------
   // Register reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] FDC_DRV_RESET = 16'h0004;  // Drive config after reset
   localparam logic [15:0] FDC_RCR_RESET = 16'h8000;  // Read config: async mode
   localparam logic [15:0] FDC_INVALID   = 16'hffff;  // Read data while busy
   // ----------------------------------------------------------------
   // Drive field layout
   // ----------------------------------------------------------------
   localparam int          FDC_DRV_MSB   = 2;         // Field 2:0
   localparam logic [2:0]  FDC_CODE_MIN  = 3'h1;      // Lowest legal code
   localparam logic [2:0]  FDC_CODE_MAX  = 3'h6;      // Highest legal code
   // ----------------------------------------------------------------
   // Command codes on the data bus
   // ----------------------------------------------------------------
   localparam logic [15:0] FDC_CMD_ARRAY  = 16'h00ff;
   localparam logic [15:0] FDC_CMD_STATUS = 16'h0070;
   localparam logic [15:0] FDC_CMD_IDENT  = 16'h0090;
   localparam logic [15:0] FDC_CMD_QUERY  = 16'h0098;
   localparam logic [15:0] FDC_CMD_CLRST  = 16'h0050;
   localparam logic [15:0] FDC_CMD_SETUP  = 16'h0060;  // Config / lock setup
   localparam logic [15:0] FDC_CNF_DRV    = 16'h0004;  // Drive config confirm
   localparam logic [15:0] FDC_CNF_RCR    = 16'h0003;  // Read config confirm
   // ----------------------------------------------------------------
   // Identifier-space offsets from the partition base
   // ----------------------------------------------------------------
   localparam logic [8:0]  FDC_ID_MFR  = 9'h000;
   localparam logic [8:0]  FDC_ID_DEV  = 9'h001;
   localparam logic [8:0]  FDC_ID_LOCK = 9'h002;
   localparam logic [8:0]  FDC_ID_RCR  = 9'h005;
   localparam logic [8:0]  FDC_ID_DRV  = 9'h006;
   localparam int          FDC_STAT_RDY = 7;          // Status valid bit
   // ----------------------------------------------------------------
   // Host controller APB register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  FDC_REG_ADDR   = 8'h00;    // Command address
   localparam logic [7:0]  FDC_REG_DATA   = 8'h04;    // Command data
   localparam logic [7:0]  FDC_REG_CTRL   = 8'h08;    // Bit0 write, bit1 read
   localparam logic [7:0]  FDC_REG_RESULT = 8'h0c;    // Read data and flags
   localparam logic [7:0]  FDC_REG_DRVCFG = 8'h10;    // Drive config load
   localparam int          FDC_RES_BUSY  = 16;
   localparam int          FDC_RES_STOK  = 17;
   localparam int          FDC_RES_ERR   = 18;
   // ----------------------------------------------------------------
   // Per-partition read mode, Gray along array-status-ident-query
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FDC_M_ARRAY  = 2'b00,
      FDC_M_STATUS = 2'b01,
      FDC_M_IDENT  = 2'b11,
      FDC_M_QUERY  = 2'b10
   } fdc_mode_t;
   // Host sequencer states
   typedef enum logic [2:0] {
      FDC_H_IDLE  = 3'b000,
      FDC_H_WR    = 3'b001,
      FDC_H_RD    = 3'b011,
      FDC_H_WAIT  = 3'b010,
      FDC_H_CONF  = 3'b110
   } fdc_hstate_t;
endpackage

/* File: rtl/fdc_link_if.sv */
`timescale 1ns/100ps
interface fdc_link_if #(
   parameter int ADDR_W = 24
);
   logic              wr;     // One-cycle command write strobe
   logic              rd;     // One-cycle read strobe
   logic [ADDR_W-1:0] addr;   // Address, carries register value on config
   logic [15:0]       wdata;  // Command code
   logic [15:0]       rdata;  // Read answer
   logic              rvalid; // One-cycle answer strobe

   // Documented device end
   modport dev (
      input  wr,
      input  rd,
      input  addr,
      input  wdata,
      output rdata,
      output rvalid
   );
   // Controller end
   modport host (
      output wr,
      output rd,
      output addr,
      output wdata,
      input  rdata,
      input  rvalid
   );
endinterface

/* File: rtl/fdc_device.sv */
`timescale 1ns/100ps
module fdc_device
   import fdc_pkg::*;
#(
   parameter int          ADDR_W    = 24,
   parameter int          PART_BITS = 3,
   parameter logic [15:0] MFR_CODE  = 16'h00a5,  // Arbitrary value
   parameter logic [15:0] DEV_CODE  = 16'h005a   // Arbitrary value
) (
   // Clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    resetn_i,
   input  wire logic                    ce_i,
   // Link to the controller
   fdc_link_if.dev                      link,
   // Array engine side
   input  wire logic [2**PART_BITS-1:0] busy_i,
   input  wire logic                    pe_start_i,
   input  wire logic [PART_BITS-1:0]    pe_part_i,
   input  wire logic                    resume_i,
   input  wire logic [PART_BITS-1:0]    resume_part_i,
   input  wire logic [15:0]             array_data_i,
   input  wire logic [15:0]             query_data_i,
   input  wire logic [6:0]              status_bits_i,
   input  wire logic [1:0]              lock_bits_i,
   // Configuration outputs
   output logic [15:0]                  drive_config_o,
   output logic [2:0]                   drive_code_o,
   output logic [15:0]                  read_config_o
);
   // One read-mode machine for each partition
   localparam int NP = 2**PART_BITS;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   fdc_mode_t             mode [NP];      // Read mode per partition
   logic                  cfg_pend;       // Setup seen, waiting confirm
   logic [15:0]           drive_config_reg;
   logic [15:0]           read_config_reg;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   // Top address bits pick the partition of a command or a read
   wire [PART_BITS-1:0] wr_part  = link.addr[ADDR_W-1 -: PART_BITS];
   wire [PART_BITS-1:0] rd_part  = link.addr[ADDR_W-1 -: PART_BITS];
   wire [15:0]          addr_val = link.addr[15:0];
   wire [8:0]           id_off   = link.addr[8:0];
   // No supply-level gating anywhere in decode
   wire cmd_array  = link.wr & ~cfg_pend & (link.wdata == FDC_CMD_ARRAY);
   wire cmd_status = link.wr & ~cfg_pend & (link.wdata == FDC_CMD_STATUS);
   wire cmd_ident  = link.wr & ~cfg_pend & (link.wdata == FDC_CMD_IDENT);
   wire cmd_query  = link.wr & ~cfg_pend & (link.wdata == FDC_CMD_QUERY);
   wire cmd_clrst  = link.wr & ~cfg_pend & (link.wdata == FDC_CMD_CLRST);
   wire cmd_setup  = link.wr & ~cfg_pend & (link.wdata == FDC_CMD_SETUP);
   // Confirm cycles only count right after a setup
   wire cnf_any    = link.wr & cfg_pend;
   wire cnf_drv    = cnf_any & (link.wdata == FDC_CNF_DRV);
   wire cnf_rcr    = cnf_any & (link.wdata == FDC_CNF_RCR);
   // Any other confirm is a lock operation: partition stays in status
   wire cnf_cfg    = cnf_drv | cnf_rcr;

   // ----------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------
   // A busy partition hides array, ident and query data
   wire       rd_busy = busy_i[rd_part];
   wire [15:0] status_word = {8'h00, ~rd_busy, status_bits_i};
   logic [15:0] id_word;
   // Identifier space decode
   always_comb begin
      case (id_off)
         FDC_ID_MFR:  id_word = MFR_CODE;
         FDC_ID_DEV:  id_word = DEV_CODE;
         FDC_ID_LOCK: id_word = {14'h0000, lock_bits_i};
         FDC_ID_RCR:  id_word = read_config_reg;
         FDC_ID_DRV:  id_word = drive_config_reg;
         default:     id_word = 16'h0000;
      endcase
   end
   // Word handed to the link on a read
   logic [15:0] next_rdata;
   // Mode of the addressed partition picks the source
   always_comb begin
      case (mode[rd_part])
         FDC_M_ARRAY:  next_rdata = rd_busy ? FDC_INVALID : array_data_i;
         FDC_M_STATUS: next_rdata = status_word;
         FDC_M_IDENT:  next_rdata = rd_busy ? FDC_INVALID : id_word;
         FDC_M_QUERY:  next_rdata = rd_busy ? FDC_INVALID : query_data_i;
         default:      next_rdata = FDC_INVALID;
      endcase
   end

   // ----------------------------------------------------------------
   // Per-partition read-mode machine
   // ----------------------------------------------------------------
   fdc_mode_t next_mode [NP];
   // Array engine events outrank commands in the same cycle, since a
   // started program or erase must always be visible in status mode.
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         next_mode[p] = mode[p];
         // Commands act only on the partition that they address
         if (link.wr && wr_part == PART_BITS'(p)) begin
            if (cmd_array)
               next_mode[p] = FDC_M_ARRAY;
            else if (cmd_status || cmd_clrst)
               next_mode[p] = FDC_M_STATUS;
            else if (cmd_ident)
               next_mode[p] = FDC_M_IDENT;
            else if (cmd_query)
               next_mode[p] = FDC_M_QUERY;
            else if (cmd_setup)
               next_mode[p] = FDC_M_STATUS;
            else if (cnf_cfg)
               next_mode[p] = FDC_M_ARRAY;
            else if (cnf_any)
               next_mode[p] = FDC_M_STATUS;
         end
         // Program/erase start moves any mode to status
         if (pe_start_i && pe_part_i == PART_BITS'(p))
            next_mode[p] = FDC_M_STATUS;
         // Resume after suspend returns to status
         if (resume_i && resume_part_i == PART_BITS'(p))
            next_mode[p] = FDC_M_STATUS;
      end
   end

   // Mode registers, all array after reset
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int p = 0; p < NP; p++)
            mode[p] <= FDC_M_ARRAY;
      end else if (ce_i) begin
         for (int p = 0; p < NP; p++)
            mode[p] <= next_mode[p];
      end
   end

   // ----------------------------------------------------------------
   // Setup tracking and configuration registers
   // ----------------------------------------------------------------
   // Confirm takes the value from its own address cycle
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_pend         <= 1'b0;
         drive_config_reg <= FDC_DRV_RESET;
         read_config_reg  <= FDC_RCR_RESET;
      end else if (ce_i) begin
         // A setup arms the confirm; the very next write disarms it
         if (cmd_setup) begin
            cfg_pend <= 1'b1;
         end else if (cnf_any) begin
            cfg_pend <= 1'b0;
         end
         // Reserved bits are stored as written; the host masks them
         if (cnf_drv)
            drive_config_reg <= addr_val;
         if (cnf_rcr)
            read_config_reg <= addr_val;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from flops
   // ----------------------------------------------------------------
   // Reserved codes are passed through unchanged; the pad decides.
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         link.rdata     <= 16'h0000;
         link.rvalid    <= 1'b0;
         drive_config_o <= FDC_DRV_RESET;
         drive_code_o   <= FDC_DRV_RESET[FDC_DRV_MSB:0];
         read_config_o  <= FDC_RCR_RESET;
      end else if (ce_i) begin
         // Answer one cycle after the read strobe
         link.rvalid    <= link.rd;
         if (link.rd)
            link.rdata  <= next_rdata;
         // Drive outputs lag the register by one cycle
         drive_config_o <= drive_config_reg;
         drive_code_o   <= drive_config_reg[FDC_DRV_MSB:0];
         read_config_o  <= read_config_reg;
      end
   end
endmodule

/* File: rtl/fdc_host.sv */
`timescale 1ns/100ps
module fdc_host
   import fdc_pkg::*;
#(
   parameter int ADDR_W     = 24,
   parameter int PART_BITS  = 3,
   parameter int ADDR_SHIFT = 0     // Host-to-device address offset
) (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        ce_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic [31:0]      prdata_o,
   output logic             pslverr_o,
   // Link to the device
   fdc_link_if.host         link
);
   // ----------------------------------------------------------------
   // Registers and sequencer
   // ----------------------------------------------------------------
   fdc_hstate_t       state;
   logic [ADDR_W-1:0] cmd_addr;     // Software command address
   logic [15:0]       cmd_data;     // Software command data
   logic [15:0]       result;       // Last read answer
   logic              cfg_err;      // Last drive load refused
   logic [15:0]       conf_code;    // Second cycle data

   // APB decode, one wait state per access
   wire acc  = psel_i & penable_i & ~pready_o;
   wire wr   = acc & pwrite_i;
   wire busy = (state != FDC_H_IDLE);
   wire w_ctrl = wr & (paddr_i == FDC_REG_CTRL) & ~busy;
   wire w_drv  = wr & (paddr_i == FDC_REG_DRVCFG) & ~busy;
   wire [2:0] code = pwdata_i[2:0];
   wire code_ok = (code >= FDC_CODE_MIN) && (code <= FDC_CODE_MAX);
   // Reserved bits forced to zero, then shifted onto the wiring
   wire [15:0] drv_val = {13'h0000, code};
   wire [ADDR_W-1:0] part_base = {cmd_addr[ADDR_W-1 -: PART_BITS],
                                  (ADDR_W-PART_BITS)'(0)};
   wire [ADDR_W-1:0] drv_addr = part_base | (ADDR_W'(drv_val) << ADDR_SHIFT);
   wire [31:0] res_word = {13'h0000, cfg_err, result[FDC_STAT_RDY], busy, result};
   wire [31:0] rd_mux = (paddr_i == FDC_REG_ADDR)   ? 32'(cmd_addr) :
                        (paddr_i == FDC_REG_DATA)   ? {16'h0000, cmd_data} :
                        (paddr_i == FDC_REG_RESULT) ? res_word : 32'h0000_0000;

   // APB answer and register writes
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
         cmd_addr  <= '0;
         cmd_data  <= 16'h0000;
      end else if (ce_i) begin
         pready_o  <= acc;
         pslverr_o <= 1'b0;
         if (acc && !pwrite_i)
            prdata_o <= rd_mux;
         if (wr && paddr_i == FDC_REG_ADDR)
            cmd_addr <= pwdata_i[ADDR_W-1:0];
         if (wr && paddr_i == FDC_REG_DATA)
            cmd_data <= pwdata_i[15:0];
      end
   end

   // ----------------------------------------------------------------
   // Link sequencer
   // ----------------------------------------------------------------
   // Strobes last one cycle; a read waits for the device answer
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state      <= FDC_H_IDLE;
         link.wr    <= 1'b0;
         link.rd    <= 1'b0;
         link.addr  <= '0;
         link.wdata <= 16'h0000;
         result     <= 16'h0000;
         cfg_err    <= 1'b0;
         conf_code  <= 16'h0000;
      end else if (ce_i) begin
         link.wr <= 1'b0;
         link.rd <= 1'b0;
         case (state)
            FDC_H_IDLE: begin
               if (w_drv && code_ok) begin
                  link.wr    <= 1'b1;
                  link.addr  <= drv_addr;
                  link.wdata <= FDC_CMD_SETUP;
                  conf_code  <= FDC_CNF_DRV;
                  cfg_err    <= 1'b0;
                  state      <= FDC_H_CONF;
               end else if (w_drv) begin
                  cfg_err <= 1'b1;
               end else if (w_ctrl && pwdata_i[0]) begin
                  link.wr    <= 1'b1;
                  link.addr  <= cmd_addr;
                  link.wdata <= cmd_data;
                  state      <= FDC_H_WR;
               end else if (w_ctrl && pwdata_i[1]) begin
                  link.rd   <= 1'b1;
                  link.addr <= cmd_addr;
                  state     <= FDC_H_WAIT;
               end
            end
            FDC_H_CONF: begin
               // Same address again with the confirm code
               link.wr    <= 1'b1;
               link.wdata <= conf_code;
               state      <= FDC_H_WR;
            end
            FDC_H_WAIT: begin
               if (link.rvalid) begin
                  result <= link.rdata;
                  state  <= FDC_H_IDLE;
               end
            end
            FDC_H_WR: state <= FDC_H_IDLE;
            default:  state <= FDC_H_IDLE;
         endcase
      end
   end
endmodule

/* File: dv/fdc_link_checker.sv */
`timescale 1ns/100ps
module fdc_link_checker
   import fdc_pkg::*;
#(
   parameter int ADDR_W = 24
) (
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              resetn_i,
   // Link signals
   input  wire logic              wr,
   input  wire logic              rd,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [15:0]       wdata,
   input  wire logic [15:0]       rdata,
   input  wire logic              rvalid
);
   // ----------------------------------------------------------------
   // Decodes of the command stream
   // ----------------------------------------------------------------
   wire cfg_setup = wr && (wdata == FDC_CMD_SETUP);  // Config load, first cycle
   wire code_ok   = addr[2:0] >= FDC_CODE_MIN && addr[2:0] <= FDC_CODE_MAX;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // ----------------------------------------------------------------
   // Link properties
   // ----------------------------------------------------------------
   // Reset holds the link quiet; no disable so reset itself is watched
   a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |->
      !wr && !rd && !rvalid && rdata == 16'h0000)
      else $error("link not idle in reset");
   a_rd_answer: assert property (rd |=> rvalid)
      else $error("read not answered next cycle");
   a_no_stray: assert property (rvalid |-> $past(rd))
      else $error("answer without read");
   a_rd_single: assert property (rd |=> !rd && !wr)
      else $error("second op during read");
   a_rdata_hold: assert property (!rd |=> $stable(rdata))
      else $error("read data moved without read");
   // Setup is always followed at once by the drive confirm, same address
   a_cfg_confirm: assert property (cfg_setup |=>
      wr && wdata == FDC_CNF_DRV && $stable(addr))
      else $error("setup not followed by confirm");
   a_cfg_reserved: assert property (cfg_setup |-> addr[15:3] == 13'h0000)
      else $error("reserved bits set in load");
   a_cfg_code: assert property (cfg_setup |-> code_ok)
      else $error("reserved drive code sent");
   a_cfg_done: assert property (cfg_setup ##1 wr |=> !wr [*2])
      else $error("extra write after confirm");
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import fdc_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observation
   // ----------------------------------------------------------------
   logic        clock_i, resetn_i, psel, penable, pwrite, pready, pslverr, slv;
   logic [7:0]  paddr, busy;
   logic [31:0] pwdata, prdata, r;
   logic        pe_start, resume;
   logic [2:0]  pe_part, res_part, code_o, cd;
   logic [15:0] arr, qry, drv_o, rcr_o, drv_exp;
   logic [6:0]  sts;
   logic [1:0]  lck;
   integer      seed = 32'h6f62;
   int          n_errors, samples_checked, i, p;
   fdc_mode_t   md [8];                        // Expected mode per partition
   logic [15:0] cmds [5] = '{16'h00ff, 16'h0070, 16'h0090, 16'h0098, 16'h0050};
   logic [2:0]  codes [5] = '{3'h1, 3'h6, 3'h0, 3'h7, 3'h4};
   logic [8:0]  offs [5] = '{9'h000, 9'h001, 9'h002, 9'h005, 9'h006};

   fdc_link_if #(.ADDR_W(24)) u_fdc_link_if ();
   fdc_host u_fdc_host (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .link(u_fdc_link_if));
   fdc_device u_fdc_device (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .link(u_fdc_link_if), .busy_i(busy), .pe_start_i(pe_start), .pe_part_i(pe_part),
      .resume_i(resume), .resume_part_i(res_part), .array_data_i(arr), .query_data_i(qry),
      .status_bits_i(sts), .lock_bits_i(lck), .drive_config_o(drv_o),
      .drive_code_o(code_o), .read_config_o(rcr_o));
   fdc_link_checker #(.ADDR_W(24)) u_fdc_link_checker (.clock_i(clock_i),
      .resetn_i(resetn_i), .wr(u_fdc_link_if.wr), .rd(u_fdc_link_if.rd),
      .addr(u_fdc_link_if.addr), .wdata(u_fdc_link_if.wdata),
      .rdata(u_fdc_link_if.rdata), .rvalid(u_fdc_link_if.rvalid));

   // Free-running 125 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   // ----------------------------------------------------------------
   // Tasks and expectation
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task complete_run;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One APB transfer; holds everything until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do @(posedge clock_i);
      while (pready !== 1'b1);
      r = prdata;
      slv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Poll the sequencer until it is idle; a hang is left to the watchdog
   task automatic poll;
      do apb(1'b0, FDC_REG_RESULT, 32'h0);
      while (r[FDC_RES_BUSY] !== 1'b0);
   endtask
   function automatic logic [15:0] expv(input int q, input logic [8:0] off);
      case (md[q])
         FDC_M_ARRAY:  expv = busy[q] ? FDC_INVALID : arr;
         FDC_M_STATUS: expv = {8'h00, ~busy[q], sts};
         FDC_M_QUERY:  expv = busy[q] ? FDC_INVALID : qry;
         default:      expv = busy[q] ? FDC_INVALID : off == FDC_ID_MFR ? 16'h00a5 :
            off == FDC_ID_DEV ? 16'h005a : off == FDC_ID_LOCK ? {14'h0000, lck} :
            off == FDC_ID_RCR ? FDC_RCR_RESET : off == FDC_ID_DRV ? drv_exp : 16'h0000;
      endcase
   endfunction
   // Command write to a partition, tracking the mode it selects
   task automatic cmd(input int q, input int k);
      apb(1'b1, FDC_REG_ADDR, q << 21);
      apb(1'b1, FDC_REG_DATA, {16'h0000, cmds[k]});
      apb(1'b1, FDC_REG_CTRL, 32'h1);
      poll();
      md[q] = fdc_mode_t'(k == 0 ? FDC_M_ARRAY : k == 2 ? FDC_M_IDENT :
         k == 3 ? FDC_M_QUERY : FDC_M_STATUS);
   endtask
   task automatic rdchk(input int q, input logic [8:0] off);
      logic [15:0] e;
      apb(1'b1, FDC_REG_ADDR, (q << 21) | off);
      apb(1'b1, FDC_REG_CTRL, 32'h2);
      poll();
      e = expv(q, off);
      chk("rdata", r[15:0], e);
      chk("stok", r[FDC_RES_STOK], e[FDC_STAT_RDY]);
      chk("slverr", slv, 1'b0);
   endtask
   task automatic pulse(input logic st, input logic [2:0] q);
      @(posedge clock_i);
      pe_start <= st;
      resume   <= ~st;
      pe_part  <= q;
      res_part <= q;
      @(posedge clock_i);
      pe_start <= 1'b0;
      resume   <= 1'b0;
      md[q] = FDC_M_STATUS;
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, busy, pe_start, resume} = '0;
      {pe_part, res_part, sts, lck} = '0;
      arr = 16'h1234;
      qry = 16'h4321;
      resetn_i = 1'b0;
      drv_exp = FDC_DRV_RESET;
      foreach (md[j]) md[j] = FDC_M_ARRAY;
      repeat (12) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      chk("drv", drv_o, 16'h0004);
      chk("code", code_o, 3'h4);
      chk("rcr", rcr_o, FDC_RCR_RESET);
      for (p = 0; p < 8; p++) rdchk(p, 9'h000);
      for (i = 0; i < 4; i++) begin
         cmd(2, i);
         rdchk(2, 9'h000);
         rdchk(3, 9'h000);
      end
      for (i = 0; i < 6; i++) begin
         cd = i < 5 ? codes[i] : 3'(1 + $unsigned($random(seed)) % 6);
         cmd(5, 2);
         apb(1'b1, FDC_REG_ADDR, 5 << 21);
         apb(1'b1, FDC_REG_DRVCFG, {29'h0, cd});
         poll();
         chk("err", r[FDC_RES_ERR], cd == 3'h0 || cd == 3'h7);
         if (cd != 3'h0 && cd != 3'h7) begin
            drv_exp = {13'h0000, cd};
            md[5] = FDC_M_ARRAY;
         end
         repeat (2) @(posedge clock_i);
         chk("drv", drv_o, drv_exp);
         chk("code", code_o, drv_exp[2:0]);
         rdchk(5, 9'h000);
      end
      cmd(5, 2);
      for (i = 0; i < 5; i++) rdchk(5, offs[i]);
      // Mid-run reset: loaded drive code and ident mode must both go
      resetn_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      drv_exp = FDC_DRV_RESET;
      foreach (md[j]) md[j] = FDC_M_ARRAY;
      @(posedge clock_i);
      chk("drv", drv_o, FDC_DRV_RESET);
      rdchk(5, 9'h000);
      cmd(3, 4);
      rdchk(3, 9'h000);
      busy[1] <= 1'b1;
      cmd(1, 0);
      rdchk(1, 9'h000);
      pulse(1'b0, 3'h1);
      rdchk(1, 9'h000);
      busy[1] <= 1'b0;
      cmd(6, 2);
      pulse(1'b1, 3'h6);
      pulse(1'b1, 3'h4);
      rdchk(6, 9'h000);
      rdchk(4, 9'h000);
      for (i = 0; i < 24; i++) begin
         @(posedge clock_i);
         arr <= $random(seed);
         qry <= $random(seed);
         sts <= $random(seed);
         lck <= $random(seed);
         p = $unsigned($random(seed)) % 8;
         cmd(p, $unsigned($random(seed)) % 5);
         rdchk(p, offs[$unsigned($random(seed)) % 5]);
      end
      complete_run();
   end
   initial begin
      #(8 * 60000);
      n_errors++;
      complete_run();
   end
endmodule
